/* File: test/mrs_ctrl_model.sv */
// controller model: register bus master issuing mode register commands
`timescale 1ns/1ps
module mrs_ctrl_model (
  input  wire logic        clk,
  input  wire logic        waitrequest,
  input  wire logic [31:0] readdata,
  output logic [7:0]       address,
  output logic             read,
  output logic             write,
  output logic [31:0]      writedata
);
  logic [31:0] rdVal;
  initial
  begin
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h00000000;
  end
  // enter just after a rising edge; one idle edge after release
  task automatic busXfer(input logic isRd, input logic [7:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    read <= isRd;
    write <= !isRd;
    do
      @(posedge clk);
    while (waitrequest !== 1'b0);
    rdVal = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask : busXfer
  // reserved bits of MR1 to MR3 masked low, except bits 15:13 of MR1 and MR2 (MR0 value sent as given); BA2 always sent low
  task automatic mrs(input logic [1:0] bank, input logic [15:0] val);
    logic [15:0] m;
    m = (bank == 2'h1) ? (val & 16'hF2FF) :
        (bank == 2'h2) ? (val & 16'hE6FF) :
        (bank == 2'h3) ? (val & 16'h0007) : val;
    busXfer(1'b0, 8'h00, {m, 12'h000, 1'b0, bank, 1'b1});
  endtask : mrs
endmodule : mrs_ctrl_model

/* File: test/tb_mode_reg_config.sv */
// self-checking bench for the mode register configuration block
`timescale 1ns/1ps
module tb_mode_reg_config;
  localparam int TDLLK = 512;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  address;
  logic        read, write, waitrequest, dllRunning, outputsOff, dynOdtAllowed;
  logic [31:0] writedata, readdata;
  logic        mprActive, srtHighRate, asrThermal, intCmdValid, intCmdWrite, intReadIsMpr;
  logic [1:0]  mprSelect;
  logic [4:0]  readLatency, writeLatency;
  logic        pulseWr, pulseMpr;
  int          err_count = 0, cmp_count = 0, cyc = 0, takeCyc = 0, pulseCyc = 0, al;
  logic [1:0]  evSeq [6] = '{2'h1, 2'h2, 2'h3, 2'h2, 2'h3, 2'h2};
  logic        dllExp [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
  always #25 clk = ~clk;
  mrs_ctrl_model ctrl (.clk(clk), .waitrequest(waitrequest), .readdata(readdata),
    .address(address), .read(read), .write(write), .writedata(writedata));
  mode_reg_config uut (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .dllRunning(dllRunning), .outputsOff(outputsOff),
    .dynOdtAllowed(dynOdtAllowed), .mprActive(mprActive), .mprSelect(mprSelect),
    .srtHighRate(srtHighRate), .asrThermal(asrThermal), .readLatency(readLatency),
    .writeLatency(writeLatency), .intCmdValid(intCmdValid),
    .intCmdWrite(intCmdWrite), .intReadIsMpr(intReadIsMpr));
  // edge stamps of command take and internal pulse
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (write && !waitrequest && address == 8'h00 && writedata[6])
      takeCyc <= cyc - 1;
    if (intCmdValid === 1'b1)
    begin
      pulseCyc <= cyc;
      pulseWr <= intCmdWrite;
      pulseMpr <= intReadIsMpr;
    end
    if (cyc == 20000)
    begin
      err_count++;
      end_of_test();
    end
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask : settle
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (16) @(posedge clk);
    chk("waitrequest", waitrequest, 1);
    chk("readLatency", readLatency, 0);
    rst_n <= 1'b1;
    settle();
    ctrl.mrs(2'h0, 16'h1120); // CL 6, fast exit, DLL reset
    ctrl.busXfer(1'b1, 8'h04, 32'h0);
    chk("mr0", ctrl.rdVal, 32'h00001020);
    repeat (TDLLK) @(posedge clk);
    ctrl.mrs(2'h2, 16'h0208); // CWL 6, Rtt_WR on
    for (int c = 0; c < 4; c++)
    begin
      al = (c == 1) ? 5 : (c == 2) ? 4 : 0; // reserved code acts as zero
      ctrl.mrs(2'h1, 16'(c << 3) | 16'h0004);
      settle();
      chk("readLatency", readLatency, al + 6);
      chk("writeLatency", writeLatency, al + 6);
      ctrl.busXfer(1'b1, 8'h18, 32'h0);
      chk("statusAl", ctrl.rdVal[7:3], al);
      ctrl.busXfer(1'b0, 8'h00, {24'h0, c[0], 7'h40});
      repeat (12) @(posedge clk);
      chk("intDelay", pulseCyc - takeCyc, al + 2);
      chk("intWrite", pulseWr, c[0]);
    end
    $display("latency test done");
    for (int s = 0; s < 4; s++)
    begin
      ctrl.mrs(2'h2, 16'h0208 | 16'(s << 6));
      settle();
      chk("asrThermal", asrThermal, s[0]);
      chk("srtHighRate", srtHighRate, s[1] & !s[0]);
      chk("dynOdt", dynOdtAllowed, 1);
    end
    ctrl.mrs(2'h1, 16'h0084); // write leveling with RZQ/4
    settle();
    chk("dynOdt", dynOdtAllowed, 0);
    chk("asrThermal", asrThermal, 1);
    ctrl.mrs(2'h1, 16'h1000);
    settle();
    chk("outputsOff", outputsOff, 1);
    chk("readLatency", readLatency, 6);
    ctrl.busXfer(1'b1, 8'h08, 32'h0);
    chk("mr1", ctrl.rdVal, 32'h00001000);
    $display("mode field test done");
    ctrl.mrs(2'h3, 16'h0003);
    settle();
    chk("mprSelect", mprSelect, 0);
    ctrl.mrs(2'h3, 16'h0006);
    settle();
    chk("mprActive", mprActive, 1);
    chk("mprSelect", mprSelect, 2);
    ctrl.busXfer(1'b0, 8'h00, 32'h40); // only reads while pattern on
    repeat (12) @(posedge clk);
    chk("mprRead", pulseMpr, 1);
    chk("mprWrite", pulseWr, 0);
    ctrl.mrs(2'h3, 16'h0000);
    settle();
    chk("mprActive", mprActive, 0);
    $display("pattern test done");
    ctrl.mrs(2'h1, 16'h0000);
    for (int k = 0; k < 6; k++)
    begin
      if (k == 2 || k == 4)
        ctrl.mrs(2'h0, {3'h0, k == 4, 12'h020});
      ctrl.busXfer(1'b0, 8'h00, {26'h0, evSeq[k], 4'h0});
      settle();
      chk("dllRunning", dllRunning, dllExp[k]);
    end
    ctrl.mrs(2'h2, 16'h0008);
    ctrl.mrs(2'h1, 16'h1001);
    settle();
    ctrl.busXfer(1'b1, 8'h18, 32'h0);
    chk("statusDll", ctrl.rdVal[0], 0);
    ctrl.busXfer(1'b1, 8'h20, 32'h0);
    chk("unmapped", ctrl.rdVal, 32'hDEADBEEF);
    $display("dll test done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("outputsOff", outputsOff, 0);
    rst_n <= 1'b1;
    settle();
    chk("outputsOff", outputsOff, 0);
    $display("reset test done");
    end_of_test();
  end
endmodule : tb_mode_reg_config

/* File: verilog/cmd_delay_line.sv */
// shift line that holds a command for the additive latency
`timescale 1ns/1ps
`include "mode_reg_defines.svh"
module cmd_delay_line (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               inValid,
  input  wire logic               inWrite,
  input  wire logic [4:0]         delay,
  output logic                    outValid,
  output logic                    outWrite
);
  logic [31:0]         vbits;
  logic [31:0]         wbits;
  // delay 0 passes straight through one flop stage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vbits <= 32'h00000000;
      wbits <= 32'h00000000;
    end
    else
    begin
      vbits <= {vbits[30:0], inValid};
      wbits <= {wbits[30:0], inWrite};
    end
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      outValid <= 1'b0;
      outWrite <= 1'b0;
    end
    else if (delay == 5'h00)
    begin
      outValid <= inValid;
      outWrite <= inWrite;
    end
    else
    begin
      outValid <= vbits[delay - 5'h01];
      outWrite <= wbits[delay - 5'h01];
    end
  end
endmodule : cmd_delay_line

/* File: verilog/mode_reg_config.sv */
// DDR3 mode-register configuration: register file, command decode, latencies
`timescale 1ns/1ps
`include "mode_reg_defines.svh"
module mode_reg_config (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  output logic             dllRunning,
  output logic             outputsOff,
  output logic             dynOdtAllowed,
  output logic             mprActive,
  output logic [1:0]       mprSelect,
  output logic             srtHighRate,
  output logic             asrThermal,
  output logic [4:0]       readLatency,
  output logic [4:0]       writeLatency,
  output logic             intCmdValid,
  output logic             intCmdWrite,
  output logic             intReadIsMpr
);
  logic [15:0] mr0;
  logic [15:0] mr1;
  logic [15:0] mr2;
  logic [15:0] mr3;
  logic        inSelfRefresh;
  logic        inPowerDown;
  logic        ackPending;
  logic [4:0]  clValue;
  logic [4:0]  cwlValue;
  logic [4:0]  alValue;
  logic        delValid;
  logic        delWrite;
  logic        busHit;
  logic [2:0]  bank;
  logic        mrsGo;
  logic        cmdRdWr;
  logic        cmdIsWrite;
  mode_reg_pkg::ev_kind_e evKind;

  // command register: go, bank[3:1], event[5:4], rd/wr [6], iswrite [7], addr [31:16]
  assign mrsGo      = write && !ackPending && address == `OFS_CMD && writedata[`BIT_CMD_GO];
  assign bank       = writedata[3:1];
  assign evKind     = mode_reg_pkg::ev_kind_e'(writedata[5:4]);
  assign cmdRdWr    = write && !ackPending && address == `OFS_CMD && writedata[6];
  assign cmdIsWrite = writedata[7];
  assign busHit     = address == `OFS_CMD || address == `OFS_MR0 || address == `OFS_MR1
                    || address == `OFS_MR2 || address == `OFS_MR3 || address == `OFS_STATUS;

  // one wait cycle per access: answer on the second edge
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ackPending <= 1'b0;
    else if ((read || write) && !ackPending)
      ackPending <= 1'b1;
    else
      ackPending <= 1'b0;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      waitrequest <= 1'b1;
    else
      waitrequest <= !((read || write) && !ackPending);
  end

  // mode registers load only on MRS to their own bank
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mr0 <= `RST_MR;
      mr1 <= `RST_MR;
      mr2 <= `RST_MR;
      mr3 <= `RST_MR;
    end
    else if (mrsGo && bank[2] == 1'b0)
    begin
      case (mode_reg_pkg::mr_sel_e'(bank[1:0]))
        mode_reg_pkg::SEL_MR0: mr0 <= writedata[31:16] & ~(16'h0001 << `BIT_MR0_DLLRST);
        mode_reg_pkg::SEL_MR1: mr1 <= writedata[31:16] & `MASK_MR1;
        mode_reg_pkg::SEL_MR2: mr2 <= writedata[31:16] & `MASK_MR2;
        mode_reg_pkg::SEL_MR3: mr3 <= writedata[31:16] & `MASK_MR3;
        default: mr0 <= mr0;
      endcase
    end
  end

  // self refresh and power-down state from controller events
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      inSelfRefresh <= 1'b0;
      inPowerDown   <= 1'b0;
    end
    else if (write && !ackPending && address == `OFS_CMD)
    begin
      case (evKind)
        mode_reg_pkg::EV_SR_ENTER: inSelfRefresh <= 1'b1;
        mode_reg_pkg::EV_SR_EXIT:
        begin
          inSelfRefresh <= 1'b0;
          inPowerDown   <= 1'b0;
        end
        mode_reg_pkg::EV_PD_ENTER: inPowerDown <= 1'b1;
        default: inPowerDown <= inPowerDown;
      endcase
    end
  end

  // dll follows A0, self refresh, and the power-down exit choice
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      dllRunning <= 1'b0;
    else
      dllRunning <= !mr1[`BIT_MR1_DLLOFF] && !inSelfRefresh
                 && !(inPowerDown && !mr0[`BIT_MR0_PPD]);
  end

  // latency decode; reserved AL code treated as disabled
  assign clValue  = {1'b0, `CL_BASE} + {2'b00, mr0[6:4]};
  assign cwlValue = {1'b0, `CWL_BASE} + {2'b00, mr2[5:3]};
  always_comb
  begin
    case (mr1[4:3])
      `AL_CLM1: alValue = clValue - 5'h01;
      `AL_CLM2: alValue = clValue - 5'h02;
      default:  alValue = 5'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      readLatency  <= 5'h00;
      writeLatency <= 5'h00;
    end
    else
    begin
      readLatency  <= alValue + clValue;
      writeLatency <= alValue + cwlValue;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      outputsOff    <= 1'b0;
      dynOdtAllowed <= 1'b0;
      mprActive     <= 1'b0;
      mprSelect     <= 2'h0;
      srtHighRate   <= 1'b0;
      asrThermal    <= 1'b0;
    end
    else
    begin
      outputsOff    <= mr1[`BIT_MR1_QOFF];
      // dynamic termination off in leveling even if Rtt_WR set
      dynOdtAllowed <= (mr2[10:9] != 2'h0) && !mr1[`BIT_MR1_WLVL];
      mprActive     <= mr3[`BIT_MR3_MPR];
      mprSelect     <= mr3[`BIT_MR3_MPR] ? mr3[1:0] : 2'h0;
      asrThermal    <= mr2[`BIT_MR2_ASR];
      srtHighRate   <= mr2[`BIT_MR2_ASR] ? 1'b0 : mr2[`BIT_MR2_SRT];
    end
  end

  cmd_delay_line u_delay (
    .clk      (clk),
    .rst_n    (rst_n),
    .inValid  (cmdRdWr),
    .inWrite  (cmdIsWrite),
    .delay    (alValue),
    .outValid (delValid),
    .outWrite (delWrite)
  );

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      intCmdValid  <= 1'b0;
      intCmdWrite  <= 1'b0;
      intReadIsMpr <= 1'b0;
    end
    else
    begin
      intCmdValid  <= delValid;
      intCmdWrite  <= delWrite;
      intReadIsMpr <= delValid && !delWrite && mr3[`BIT_MR3_MPR];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      readdata <= 32'h00000000;
    else if (read && !ackPending)
    begin
      case (address)
        `OFS_MR0:    readdata <= {16'h0000, mr0};
        `OFS_MR1:    readdata <= {16'h0000, mr1};
        `OFS_MR2:    readdata <= {16'h0000, mr2};
        `OFS_MR3:    readdata <= {16'h0000, mr3};
        `OFS_STATUS: readdata <= {24'h000000, alValue, inPowerDown, inSelfRefresh, dllRunning};
        default:     readdata <= busHit ? 32'h00000000 : 32'hDEADBEEF;
      endcase
    end
  end

  // rst_n in antecedents: flops still in reset on the release edge
  a_mr1_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !(mrsGo && bank == 3'h1) |=> $stable(mr1)) else $error("mr1 changed without mrs");
  a_mr1_load: assert property (@(posedge clk) disable iff (!rst_n)
    (mrsGo && bank == 3'h1) |=> mr1 == ($past(writedata[31:16]) & `MASK_MR1))
    else $error("mr1 not loaded");
  a_mr2_load: assert property (@(posedge clk) disable iff (!rst_n)
    (mrsGo && bank == 3'h2) |=> mr2 == ($past(writedata[31:16]) & `MASK_MR2))
    else $error("mr2 not loaded");
  a_mr3_load: assert property (@(posedge clk) disable iff (!rst_n)
    (mrsGo && bank == 3'h3) |=> mr3 == ($past(writedata[31:16]) & `MASK_MR3))
    else $error("mr3 not loaded");
  a_mr0_load: assert property (@(posedge clk) disable iff (!rst_n)
    (mrsGo && bank == 3'h0) |=> mr0 == ($past(writedata[31:16]) & 16'hFEFF))
    else $error("mr0 not loaded");
  a_mr0_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !(mrsGo && bank == 3'h0) |=> $stable(mr0)) else $error("mr0 changed without mrs");
  a_mr2_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !(mrsGo && bank == 3'h2) |=> $stable(mr2)) else $error("mr2 changed without mrs");
  a_mr3_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !(mrsGo && bank == 3'h3) |=> $stable(mr3)) else $error("mr3 changed without mrs");
  a_dll_selfref: assert property (@(posedge clk) disable iff (!rst_n)
    inSelfRefresh |=> !dllRunning) else $error("dll running in self refresh");
  a_dll_normal: assert property (@(posedge clk) disable iff (!rst_n)
    (rst_n && !mr1[`BIT_MR1_DLLOFF] && !inSelfRefresh && !inPowerDown) |=> dllRunning)
    else $error("dll stopped in normal operation");
  a_dll_slowexit: assert property (@(posedge clk) disable iff (!rst_n)
    (inPowerDown && !mr0[`BIT_MR0_PPD]) |=> !dllRunning) else $error("dll not frozen");
  a_dll_fastexit: assert property (@(posedge clk) disable iff (!rst_n)
    (inPowerDown && mr0[`BIT_MR0_PPD] && !inSelfRefresh && !mr1[0]) |=> dllRunning)
    else $error("dll stopped in fast exit");
  a_al_decode: assert property (@(posedge clk) disable iff (!rst_n)
    (mr1[4:3] == `AL_CLM2) |-> alValue == clValue - 5'h02) else $error("al decode");
  a_al_clm1: assert property (@(posedge clk) disable iff (!rst_n)
    (mr1[4:3] == `AL_CLM1) |-> alValue == clValue - 5'h01) else $error("al decode minus one");
  a_al_reserved: assert property (@(posedge clk) disable iff (!rst_n)
    (mr1[4:3] == 2'h3) |-> alValue == 5'h00) else $error("reserved al not zero");
  a_wl_sum: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n |=> writeLatency == $past(alValue) + $past(cwlValue)) else $error("wl sum");
  a_rl_sum: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n |=> readLatency == $past(alValue) + $past(clValue)) else $error("rl sum");
  a_qoff_out: assert property (@(posedge clk) disable iff (!rst_n)
    mr1[`BIT_MR1_QOFF] |=> outputsOff) else $error("outputs not off");
  a_qoff_clear: assert property (@(posedge clk) disable iff (!rst_n)
    !mr1[`BIT_MR1_QOFF] |=> !outputsOff) else $error("outputs off in normal mode");
  a_wlvl_nodyn: assert property (@(posedge clk) disable iff (!rst_n)
    mr1[`BIT_MR1_WLVL] |=> !dynOdtAllowed) else $error("dynamic odt in leveling");
  a_mpr_ignore: assert property (@(posedge clk) disable iff (!rst_n)
    !mr3[`BIT_MR3_MPR] |=> mprSelect == 2'h0) else $error("mpr select not ignored");
  a_mpr_select: assert property (@(posedge clk) disable iff (!rst_n)
    mr3[`BIT_MR3_MPR] |=> mprSelect == $past(mr3[1:0])) else $error("mpr select lost");
  a_asr_srt: assert property (@(posedge clk) disable iff (!rst_n)
    mr2[`BIT_MR2_ASR] |=> !srtHighRate) else $error("srt used with asr");
  a_al_delay: assert property (@(posedge clk) disable iff (!rst_n)
    (cmdRdWr && alValue == 5'h00 && $stable(mr1)) |-> ##2 intCmdValid)
    else $error("command lost at al zero");
  a_mpr_redirect: assert property (@(posedge clk) disable iff (!rst_n)
    (delValid && !delWrite && mr3[`BIT_MR3_MPR]) |=> intReadIsMpr)
    else $error("read not redirected");
endmodule : mode_reg_config

/* File: verilog/mode_reg_defines.svh */
// constants for the mode-register configuration block
`ifndef MODE_REG_DEFINES_SVH
`define MODE_REG_DEFINES_SVH
`define OFS_CMD        8'h00
`define OFS_MR0        8'h04
`define OFS_MR1        8'h08
`define OFS_MR2        8'h0C
`define OFS_MR3        8'h10
`define OFS_EVENT      8'h14
`define OFS_STATUS     8'h18
`define OFS_DELAY      8'h1C
`define BIT_CMD_GO     0
`define BIT_MR0_PPD    12
`define BIT_MR0_DLLRST 8
`define BIT_MR1_DLLOFF 0
`define BIT_MR1_WLVL   7
`define BIT_MR1_QOFF   12
`define BIT_MR2_SRT    7
`define BIT_MR2_ASR    6
`define BIT_MR3_MPR    2
`define RST_MR         16'h0000
`define MASK_MR1       16'h12FF
`define MASK_MR2       16'h06FF
`define MASK_MR3       16'h0007
`define AL_OFF         2'h0
`define AL_CLM1        2'h1
`define AL_CLM2        2'h2
`define CWL_BASE       4'h5
`define CL_BASE        4'h4
`define DLY_W          5
`endif

/* File: verilog/mode_reg_pkg.sv */
// types for the mode-register configuration block
package mode_reg_pkg;
  typedef enum logic [1:0] {SEL_MR0, SEL_MR1, SEL_MR2, SEL_MR3} mr_sel_e;
  typedef enum logic [1:0] {EV_NONE, EV_SR_ENTER, EV_SR_EXIT, EV_PD_ENTER} ev_kind_e;
endpackage : mode_reg_pkg
